// ---- core/ezap_access_checker.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "ezap_defs.svh"

module ezap_access_checker #(
    parameter logic [23:0] FIXED_SERIAL = 24'h12_3456,        // Arbitrary value
    parameter logic [47:0] DIE_SERIAL   = 48'h0000_0000_0000, // Arbitrary value
    parameter logic [31:0] REVISION     = 32'h0000_0000       // Arbitrary value
) (
    input  wire logic                          sys_clk,
    input  wire logic                          rst_n,
    input  wire logic                          reqValid,
    input  wire ezap_pkg::ezap_zone_type       reqZone,
    input  wire ezap_pkg::ezap_op_type         reqOp,
    input  wire logic                   [4:0]  reqAddr,
    input  wire logic                   [3:0]  reqSlot,
    input  wire logic                          reqLong,
    input  wire logic                          reqMacOk,
    input  wire logic                          reqEncrypted,
    input  wire logic                   [3:0]  reqMacKeySlot,
    input  wire logic                   [31:0] reqWrData,
    input  wire logic                          reqUseDieSerial,
    output logic                               respValid,
    output logic                               respAllow,
    output logic                               respMacNeeded,
    output logic                        [3:0]  respSourceSlot,
    output logic                        [31:0] respData,
    output logic                        [7:0]  configLockByte,
    output logic                        [7:0]  dataLockByte,
    output logic                        [71:0] serialForHash
);
    import ezap_pkg::*;

    localparam int OTP_WORDS = `EZAP_OTP_WORDS;
    localparam logic [31:0] SN_WORD0 = {DIE_SERIAL[39:32], DIE_SERIAL[47:40],
                                        FIXED_SERIAL[15:8], FIXED_SERIAL[23:16]};
    localparam logic [31:0] SN_WORD2 = {DIE_SERIAL[7:0], DIE_SERIAL[15:8],
                                        DIE_SERIAL[23:16], DIE_SERIAL[31:24]};
    localparam logic [31:0] SN_WORD3 = {24'h00_0000, FIXED_SERIAL[7:0]};

    logic [31:0] cfgMem      [`EZAP_CFG_FIRST_RW:`EZAP_LOCK_WORD];
    logic [31:0] next_cfgMem [`EZAP_CFG_FIRST_RW:`EZAP_LOCK_WORD];
    logic [31:0] otpMem      [0:OTP_WORDS-1];
    logic [31:0] next_otpMem [0:OTP_WORDS-1];

    logic        next_respValid;
    logic        next_respAllow;
    logic        next_respMacNeeded;
    logic [3:0]  next_respSourceSlot;
    logic [31:0] next_respData;
    logic [71:0] next_serialForHash;

    logic        cfgUnlocked;
    logic        dataUnlocked;
    logic [7:0]  otpPolicyByte;
    logic [4:0]  slotWord;
    logic [15:0] slotPolicy;
    logic [31:0] cfgRdWord;
    logic        cfgInRange;
    logic        otpInRange;
    logic        otpRdOk;
    logic        otpWrOk;
    logic        slotOk;
    logic        slotMac;
    logic [3:0]  slotSrc;

    assign configLockByte = cfgMem[`EZAP_LOCK_WORD][`EZAP_CFG_LOCK_LSB +: 8];
    assign dataLockByte   = cfgMem[`EZAP_LOCK_WORD][`EZAP_DATA_LOCK_LSB +: 8];
    assign cfgUnlocked    = (configLockByte == `EZAP_UNLOCKED);
    assign dataUnlocked   = (dataLockByte == `EZAP_UNLOCKED);
    assign otpPolicyByte  = cfgMem[`EZAP_MODE_WORD][`EZAP_OTP_POL_LSB +: 8];
    assign cfgInRange     = (reqAddr <= `EZAP_LOCK_WORD);
    assign otpInRange     = (reqAddr[4] == 1'b0);

    // Two slot policy words share one configuration word
    assign slotWord   = `EZAP_SLOTCFG_WORD0 + {2'h0, reqSlot[3:1]};
    assign slotPolicy = reqSlot[0] ? cfgMem[slotWord][31:16] : cfgMem[slotWord][15:0];

    ezap_slot_policy u_slot_policy (
        .policyWord (slotPolicy),
        .slot       (reqSlot),
        .op         (reqOp),
        .isLong     (reqLong),
        .macOk      (reqMacOk),
        .encrypted  (reqEncrypted),
        .macKeySlot (reqMacKeySlot),
        .allow      (slotOk),
        .macNeeded  (slotMac),
        .sourceSlot (slotSrc)
    );

    ezap_otp_policy u_otp_policy (
        .otpPolicyByte (otpPolicyByte),
        .cfgLocked     (!cfgUnlocked),
        .dataLocked    (!dataUnlocked),
        .isLong        (reqLong),
        .word          (reqAddr[3:0]),
        .readOk        (otpRdOk),
        .writeOk       (otpWrOk)
    );

    // Serial and revision words are hardwired, not stored
    always_comb begin
        cfgRdWord = 32'h0000_0000;
        if (reqAddr == 5'h00) begin
            cfgRdWord = SN_WORD0;
        end else if (reqAddr == 5'h01) begin
            cfgRdWord = REVISION;
        end else if (reqAddr == 5'h02) begin
            cfgRdWord = SN_WORD2;
        end else if (reqAddr == `EZAP_CFG_FIXED_LAST) begin
            cfgRdWord = SN_WORD3;
        end else if (cfgInRange) begin
            cfgRdWord = cfgMem[reqAddr];
        end
    end

    always_comb begin
        next_cfgMem         = cfgMem;
        next_otpMem         = otpMem;
        next_respValid      = reqValid;
        next_respAllow      = 1'b0;
        next_respMacNeeded  = 1'b0;
        next_respSourceSlot = reqSlot;
        next_respData       = 32'h0000_0000;
        next_serialForHash  = {FIXED_SERIAL, reqUseDieSerial ? DIE_SERIAL : 48'h0000_0000_0000};
        if (reqValid) begin
            case (reqZone)
                ZONE_CONFIG: begin
                    unique case (reqOp)
                        OP_READ: begin
                            next_respAllow = cfgInRange;
                            next_respData  = cfgRdWord;
                        end
                        OP_WRITE: begin
                            // Serial, revision and lock words never take a plain write
                            next_respAllow = cfgUnlocked && (reqAddr >= `EZAP_CFG_FIRST_RW)
                                             && (reqAddr <= `EZAP_CFG_LAST_RW);
                            if (next_respAllow) begin
                                next_cfgMem[reqAddr] = reqWrData;
                            end
                        end
                        OP_LOCK: begin
                            next_respAllow = cfgUnlocked;
                            if (cfgUnlocked) begin
                                next_cfgMem[`EZAP_LOCK_WORD][`EZAP_CFG_LOCK_LSB +: 8] = `EZAP_LOCKED;
                            end
                        end
                        OP_DERIVE: begin
                            next_respAllow = 1'b0;
                        end
                    endcase
                end
                ZONE_OTP, ZONE_DATA: begin
                    if (reqOp == OP_LOCK) begin
                        // One lock covers data and OTP together
                        next_respAllow = !cfgUnlocked && dataUnlocked;
                        if (next_respAllow) begin
                            next_cfgMem[`EZAP_LOCK_WORD][`EZAP_DATA_LOCK_LSB +: 8] = `EZAP_LOCKED;
                        end
                    end else if (cfgUnlocked) begin
                        next_respAllow = 1'b0;
                    end else if (reqZone == ZONE_OTP) begin
                        if (reqOp == OP_READ) begin
                            next_respAllow = otpInRange && otpRdOk;
                            next_respData  = otpMem[reqAddr[3:0]];
                        end else if (reqOp == OP_WRITE) begin
                            next_respAllow = otpInRange && otpWrOk;
                            if (next_respAllow) begin
                                next_otpMem[reqAddr[3:0]] = reqWrData;
                            end
                        end
                    end else if (dataUnlocked) begin
                        next_respAllow = (reqOp == OP_WRITE);
                    end else begin
                        next_respAllow      = slotOk;
                        next_respMacNeeded  = slotMac;
                        next_respSourceSlot = (reqOp == OP_DERIVE) ? slotSrc : reqSlot;
                    end
                end
                default: begin
                    next_respAllow = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = `EZAP_CFG_FIRST_RW; i <= `EZAP_LOCK_WORD; i++) begin
                cfgMem[i] <= `EZAP_CFG_WORD_RST;
            end
            cfgMem[`EZAP_MODE_WORD] <= `EZAP_MODE_WORD_RST;
            cfgMem[`EZAP_LOCK_WORD] <= `EZAP_LOCK_WORD_RST;
            for (int i = 0; i < OTP_WORDS; i++) begin
                otpMem[i] <= `EZAP_OTP_ERASED;
            end
            respValid      <= 1'b0;
            respAllow      <= 1'b0;
            respMacNeeded  <= 1'b0;
            respSourceSlot <= 4'h0;
            respData       <= 32'h0000_0000;
            serialForHash  <= 72'h00_0000_0000_0000_0000;
        end else begin
            cfgMem         <= next_cfgMem;
            otpMem         <= next_otpMem;
            respValid      <= next_respValid;
            respAllow      <= next_respAllow;
            respMacNeeded  <= next_respMacNeeded;
            respSourceSlot <= next_respSourceSlot;
            respData       <= next_respData;
            serialForHash  <= next_serialForHash;
        end
    end

    // Checks
    logic       polMac;
    logic       polEnc;
    logic       polDerive;
    logic       polParent;
    logic       polSecret;
    logic [3:0] polWkey;
    logic       slotsLive;
    logic       isData;

    assign polMac    = slotPolicy[`EZAP_WP_MAC];
    assign polEnc    = slotPolicy[`EZAP_WP_ENC];
    assign polDerive = slotPolicy[`EZAP_WP_DERIVE];
    assign polParent = slotPolicy[`EZAP_WP_PARENT];
    assign polSecret = slotPolicy[`EZAP_SECRET];
    assign polWkey   = slotPolicy[`EZAP_WKEY_LSB +: 4];
    assign slotsLive = !cfgUnlocked && !dataUnlocked;
    assign isData    = reqValid && (reqZone == ZONE_DATA) && slotsLive;

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_n);

    sequence s_derive_req;
        isData && (reqOp == OP_DERIVE);
    endsequence

    sequence s_cfg_lock_req;
        reqValid && (reqZone == ZONE_CONFIG) && (reqOp == OP_LOCK) && cfgUnlocked;
    endsequence

    property p_derive_b13;
        s_derive_req and (!polDerive) |=> respValid && !respAllow;
    endproperty
    a_derive_b13: assert property (p_derive_b13) else $error("derive allowed without bit 13");

    property p_derive_src;
        s_derive_req and polDerive |=> respSourceSlot == ($past(polParent) ? $past(polWkey) : $past(reqSlot));
    endproperty
    a_derive_src: assert property (p_derive_src) else $error("derive source slot wrong");

    property p_derive_mac;
        s_derive_req and (polDerive && polMac && !reqMacOk) |=> respMacNeeded && !respAllow;
    endproperty
    a_derive_mac: assert property (p_derive_mac) else $error("derive passed without MAC");

    property p_write_always;
        isData && (reqOp == OP_WRITE) && !polMac && !polEnc && !polDerive && !polSecret |=> respAllow;
    endproperty
    a_write_always: assert property (p_write_always) else $error("always-writable slot refused");

    property p_write_never;
        isData && (reqOp == OP_WRITE) && !polEnc && (polMac || polDerive) |=> !respAllow;
    endproperty
    a_write_never: assert property (p_write_never) else $error("never-write slot written");

    property p_short_secret;
        isData && (reqOp inside {OP_READ, OP_WRITE}) && !reqLong
            && (polSecret || (polEnc && (reqOp == OP_WRITE))) |=> !respAllow;
    endproperty
    a_short_secret: assert property (p_short_secret) else $error("short access to protected slot");

    property p_fixed_cfg;
        reqValid && (reqZone == ZONE_CONFIG) && (reqAddr <= `EZAP_CFG_FIXED_LAST)
            && (reqOp inside {OP_READ, OP_WRITE})
            |=> respValid && ((($past(reqOp) == OP_READ)) == respAllow);
    endproperty
    a_fixed_cfg: assert property (p_fixed_cfg) else $error("fixed config access wrong");

    property p_cfg_unlocked_err;
        reqValid && cfgUnlocked && (reqZone != ZONE_CONFIG) && (reqOp != OP_LOCK) |=> !respAllow;
    endproperty
    a_cfg_unlocked_err: assert property (p_cfg_unlocked_err) else $error("access before config lock");

    property p_cfg_lock;
        s_cfg_lock_req |=> respAllow && !cfgUnlocked ##1 !cfgUnlocked;
    endproperty
    a_cfg_lock: assert property (p_cfg_lock) else $error("config lock did not stick");

    property p_locks_sticky;
        !dataUnlocked |=> !dataUnlocked;
    endproperty
    a_locks_sticky: assert property (p_locks_sticky) else $error("data zone unlocked again");

    property p_otp_legacy;
        reqValid && (reqZone == ZONE_OTP) && slotsLive && (otpPolicyByte == `EZAP_OTP_LEGACY)
            && (reqLong || reqOp == OP_WRITE || reqAddr < 5'h02) && (reqOp != OP_LOCK) |=> !respAllow;
    endproperty
    a_otp_legacy: assert property (p_otp_legacy) else $error("legacy OTP access allowed");

    property p_answer;
        reqValid |=> respValid ##1 (respValid == $past(reqValid));
    endproperty
    a_answer: assert property (p_answer) else $error("request not answered next cycle");

endmodule

`default_nettype wire

// ---- core/ezap_defs.svh ----
`ifndef EZAP_DEFS_SVH
`define EZAP_DEFS_SVH

// Lock byte encodings
`define EZAP_UNLOCKED        8'h55
`define EZAP_LOCKED          8'h00

// Lock byte positions in the configuration zone
`define EZAP_DATA_LOCK_OFS   7'h56
`define EZAP_CFG_LOCK_OFS    7'h57
`define EZAP_DATA_LOCK_LSB   (8 * (`EZAP_DATA_LOCK_OFS % 4))
`define EZAP_CFG_LOCK_LSB    (8 * (`EZAP_CFG_LOCK_OFS % 4))

// Configuration zone word map
`define EZAP_CFG_FIXED_LAST  5'h03
`define EZAP_CFG_FIRST_RW    5'h04
`define EZAP_CFG_LAST_RW     5'h14
`define EZAP_LOCK_WORD       5'h15
`define EZAP_MODE_WORD       5'h04
`define EZAP_SLOTCFG_WORD0   5'h05
`define EZAP_OTP_POL_LSB     16

// Reset images of the stored configuration words
`define EZAP_LOCK_WORD_RST   32'h5555_0000
`define EZAP_MODE_WORD_RST   32'h0055_00C8
`define EZAP_CFG_WORD_RST    32'h0000_0000

// OTP policy byte encodings
`define EZAP_OTP_READONLY    8'hAA
`define EZAP_OTP_CONSUME     8'h55
`define EZAP_OTP_LEGACY      8'h00

// OTP zone geometry
`define EZAP_OTP_WORDS       16
`define EZAP_OTP_ERASED      32'hFFFF_FFFF
`define EZAP_LEGACY_FIRST_RD 4'h2

// Slot policy word fields
`define EZAP_WP_MAC          15
`define EZAP_WP_ENC          14
`define EZAP_WP_DERIVE       13
`define EZAP_WP_PARENT       12
`define EZAP_WKEY_LSB        8
`define EZAP_SECRET          7
`define EZAP_ENC_READ        6

`endif

// ---- core/ezap_pkg.sv ----
package ezap_pkg;

    typedef enum logic [1:0] {
        ZONE_CONFIG = 2'h0,
        ZONE_OTP    = 2'h1,
        ZONE_DATA   = 2'h2
    } ezap_zone_type;

    typedef enum logic [1:0] {
        OP_READ   = 2'h0,
        OP_WRITE  = 2'h1,
        OP_DERIVE = 2'h2,
        OP_LOCK   = 2'h3
    } ezap_op_type;

endpackage

// ---- core/ezap_slot_policy.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "ezap_defs.svh"

module ezap_slot_policy (
    input  wire logic                 [15:0] policyWord,
    input  wire logic                 [3:0]  slot,
    input  wire ezap_pkg::ezap_op_type       op,
    input  wire logic                        isLong,
    input  wire logic                        macOk,
    input  wire logic                        encrypted,
    input  wire logic                 [3:0]  macKeySlot,
    output logic                             allow,
    output logic                             macNeeded,
    output logic                      [3:0]  sourceSlot
);
    import ezap_pkg::*;

    logic       wpMac;
    logic       wpEnc;
    logic       wpDerive;
    logic [3:0] wkey;
    logic       secret;
    logic       shortBlocked;

    assign wpMac        = policyWord[`EZAP_WP_MAC];
    assign wpEnc        = policyWord[`EZAP_WP_ENC];
    assign wpDerive     = policyWord[`EZAP_WP_DERIVE];
    assign wkey         = policyWord[`EZAP_WKEY_LSB +: 4];
    assign secret       = policyWord[`EZAP_SECRET];
    assign shortBlocked = secret && !isLong;

    always_comb begin
        allow      = 1'b0;
        macNeeded  = 1'b0;
        sourceSlot = policyWord[`EZAP_WP_PARENT] ? wkey : slot;
        unique case (op)
            OP_READ: begin
                // Secret slots only leave the device encrypted
                allow = !shortBlocked && (!secret || (policyWord[`EZAP_ENC_READ] && encrypted));
            end
            OP_WRITE: begin
                macNeeded = wpEnc;
                if (!wpMac && !wpEnc && !wpDerive) begin
                    allow = !shortBlocked;
                end else if (!wpEnc) begin
                    allow = 1'b0;
                end else begin
                    // Self-pointing write key forces the MAC under the old key
                    allow = isLong && macOk && encrypted && (macKeySlot == wkey);
                end
            end
            OP_DERIVE: begin
                macNeeded = wpMac;
                allow     = wpDerive && (!wpMac || macOk);
            end
            OP_LOCK: begin
                allow = 1'b0;
            end
        endcase
    end

endmodule

`default_nettype wire

// ---- core/ezap_otp_policy.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "ezap_defs.svh"

module ezap_otp_policy (
    input  wire logic [7:0] otpPolicyByte,
    input  wire logic       cfgLocked,
    input  wire logic       dataLocked,
    input  wire logic       isLong,
    input  wire logic [3:0] word,
    output logic            readOk,
    output logic            writeOk
);

    always_comb begin
        readOk  = 1'b0;
        writeOk = 1'b0;
        if (!cfgLocked) begin
            readOk  = 1'b0;
            writeOk = 1'b0;
        end else if (!dataLocked) begin
            readOk  = 1'b0;
            writeOk = 1'b1;
        end else if (otpPolicyByte == `EZAP_OTP_READONLY) begin
            readOk  = 1'b1;
            writeOk = 1'b0;
        end else if (otpPolicyByte == `EZAP_OTP_LEGACY) begin
            readOk  = !isLong && (word >= `EZAP_LEGACY_FIRST_RD);
            writeOk = 1'b0;
        end else begin
            // Consumption and reserved codes grant nothing
            readOk  = 1'b0;
            writeOk = 1'b0;
        end
    end

endmodule

`default_nettype wire

// ---- testbench/ezap_host_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module ezap_host_model (
    input  wire logic                     sys_clk,
    input  wire logic                     respValid,
    input  wire logic                     respAllow,
    input  wire logic                     respMacNeeded,
    input  wire logic              [3:0]  respSourceSlot,
    input  wire logic              [31:0] respData,
    input  wire logic              [71:0] serialForHash,
    output var  logic                     reqValid,
    output var  ezap_pkg::ezap_zone_type  reqZone,
    output var  ezap_pkg::ezap_op_type    reqOp,
    output var  logic              [4:0]  reqAddr,
    output var  logic              [3:0]  reqSlot,
    output var  logic                     reqLong,
    output var  logic                     reqMacOk,
    output var  logic                     reqEncrypted,
    output var  logic              [3:0]  reqMacKeySlot,
    output var  logic              [31:0] reqWrData,
    output var  logic                     reqUseDieSerial
);
    import ezap_pkg::*;
    logic        rV, rA, rM;
    logic [3:0]  rS;
    logic [31:0] rD;
    logic [71:0] rH;
    initial begin
        reqValid = 1'b0;
        reqZone = ZONE_CONFIG;
        reqOp = OP_READ;
        reqAddr = 5'h00;
        reqSlot = 4'h0;
        {reqLong, reqMacOk, reqEncrypted, reqUseDieSerial} = 4'h0;
        reqMacKeySlot = 4'h0;
        reqWrData = 32'h0000_0000;
    end
    // One request per call, answer captured just after the edge that takes it
    task automatic req(input ezap_zone_type z, input ezap_op_type o, input logic [4:0] a, input logic [3:0] s,
                       input logic [3:0] f, input logic [3:0] k, input logic [31:0] d);
        @(posedge sys_clk);
        reqValid <= 1'b1;
        reqZone <= z;
        reqOp <= o;
        reqAddr <= a;
        reqSlot <= s;
        {reqLong, reqMacOk, reqEncrypted, reqUseDieSerial} <= f;
        reqMacKeySlot <= k;
        reqWrData <= d;
        @(posedge sys_clk);
        reqValid <= 1'b0;
        // Scrambled once released, so the block cannot lean on stale fields
        reqAddr <= ~a;
        reqSlot <= ~s;
        reqMacKeySlot <= ~k;
        reqWrData <= ~d;
        #1;
        rV = respValid;
        rA = respAllow;
        rM = respMacNeeded;
        rS = respSourceSlot;
        rD = respData;
        rH = serialForHash;
    endtask
endmodule
`default_nettype wire

// ---- testbench/testbench.sv ----
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, a) begin num_checks++; if ((a) !== (e)) begin errors++; $display("MISMATCH %s exp %h got %h", n, e, a); end end
module testbench;
    import ezap_pkg::*;
    localparam logic [23:0] FS = 24'hA5_A5A5; // Arbitrary value
    localparam logic [47:0] DS = 48'h1111_2222_3333; // Arbitrary value
    localparam logic [3:0]  L = 4'h8, M = 4'h4, E = 4'h2, D = 4'h1;
    logic          sys_clk = 1'b0, rst_n = 1'b0;
    logic          reqValid, reqLong, reqMacOk, reqEncrypted, reqUseDieSerial, respValid, respAllow, respMacNeeded;
    ezap_zone_type reqZone;
    ezap_op_type   reqOp;
    logic [4:0]    reqAddr;
    logic [3:0]    reqSlot, reqMacKeySlot, respSourceSlot;
    logic [31:0]   reqWrData, respData;
    logic [7:0]    configLockByte, dataLockByte;
    logic [71:0]   serialForHash;
    int            errors = 0, num_checks = 0, cycles = 0;

    ezap_access_checker #(.FIXED_SERIAL(FS), .DIE_SERIAL(DS)) uut (.sys_clk, .rst_n, .reqValid, .reqZone, .reqOp,
        .reqAddr, .reqSlot, .reqLong, .reqMacOk, .reqEncrypted, .reqMacKeySlot, .reqWrData, .reqUseDieSerial,
        .respValid, .respAllow, .respMacNeeded, .respSourceSlot, .respData, .configLockByte, .dataLockByte,
        .serialForHash);
    ezap_host_model p (.sys_clk, .respValid, .respAllow, .respMacNeeded, .respSourceSlot, .respData, .serialForHash,
        .reqValid, .reqZone, .reqOp, .reqAddr, .reqSlot, .reqLong, .reqMacOk, .reqEncrypted, .reqMacKeySlot,
        .reqWrData, .reqUseDieSerial);

    always #20 sys_clk = ~sys_clk;

    task finish_test;
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // Generous ceiling: a full run needs under two hundred cycles
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 3000) begin
            errors++;
            finish_test;
        end
    end

    task automatic t(input string n, input ezap_zone_type z, input ezap_op_type o, input logic [4:0] a,
                     input logic [3:0] s, input logic [3:0] f, input logic [3:0] k, input logic [31:0] d, input logic x);
        p.req(z, o, a, s, f, k, d);
        `CHK(n, x, p.rA)
    endtask

    task doReset;
        @(posedge sys_clk);
        rst_n <= 1'b0;
        repeat (12) @(posedge sys_clk);
        rst_n <= 1'b1;
    endtask

    task cfgPhase(input logic [7:0] pol);
        t("cfgRd", ZONE_CONFIG, OP_READ, 5'h15, 0, 0, 0, 0, 1);
        `CHK("rValid", 1'b1, p.rV)
        `CHK("lockWd", 32'h5555_0000, p.rD)
        t("snWr", ZONE_CONFIG, OP_WRITE, 5'h00, 0, 0, 0, 0, 0);
        t("revWr", ZONE_CONFIG, OP_WRITE, 5'h01, 0, 0, 0, 0, 0);
        t("otpRd0", ZONE_OTP, OP_READ, 0, 0, 0, 0, 0, 0);
        t("otpWr0", ZONE_OTP, OP_WRITE, 0, 0, 0, 0, 0, 0);
        t("slotWr0", ZONE_DATA, OP_WRITE, 0, 0, 0, 0, 0, 0);
        t("modeWr", ZONE_CONFIG, OP_WRITE, 5'h04, 0, 0, 0, {8'h00, pol, 16'h00C8}, 1);
        t("modeRd", ZONE_CONFIG, OP_READ, 5'h04, 0, 0, 0, 0, 1);
        `CHK("modeWd", {8'h00, pol, 16'h00C8}, p.rD)
        t("pol01", ZONE_CONFIG, OP_WRITE, 5'h05, 0, 0, 0, 32'h2080_0000, 1);
        t("pol23", ZONE_CONFIG, OP_WRITE, 5'h06, 0, 0, 0, 32'hB580_4380, 1);
        t("pol45", ZONE_CONFIG, OP_WRITE, 5'h07, 0, 0, 0, 32'h0080_4480, 1);
        t("pol67", ZONE_CONFIG, OP_WRITE, 5'h08, 0, 0, 0, 32'h0000_00C0, 1);
        t("die", ZONE_CONFIG, OP_READ, 0, 0, D, 0, 0, 1);
        `CHK("serDie", {FS, DS}, p.rH)
        t("noDie", ZONE_CONFIG, OP_READ, 0, 0, 0, 0, 0, 1);
        `CHK("serFix", {FS, 48'h0}, p.rH)
        t("cLock", ZONE_CONFIG, OP_LOCK, 0, 0, 0, 0, 0, 1);
        `CHK("cfgLock", 8'h00, configLockByte)
        t("cfgWrL", ZONE_CONFIG, OP_WRITE, 5'h05, 0, 0, 0, 0, 0);
        t("cfgRdL", ZONE_CONFIG, OP_READ, 5'h05, 0, 0, 0, 0, 1);
        t("cLock2", ZONE_CONFIG, OP_LOCK, 0, 0, 0, 0, 0, 0);
    endtask

    task perso;
        t("otpWrO", ZONE_OTP, OP_WRITE, 0, 0, 0, 0, 32'h1234_5678, 1);
        t("otpRdO", ZONE_OTP, OP_READ, 0, 0, L, 0, 0, 0);
        t("slotWrO", ZONE_DATA, OP_WRITE, 0, 1, 0, 0, 0, 1);
        t("slotRdO", ZONE_DATA, OP_READ, 0, 0, L, 0, 0, 0);
        t("dLock", ZONE_DATA, OP_LOCK, 0, 0, 0, 0, 0, 1);
        `CHK("datLock", 8'h00, dataLockByte)
        t("dLock2", ZONE_OTP, OP_LOCK, 0, 0, 0, 0, 0, 0);
    endtask

    task lockedRo;
        t("roRdL", ZONE_OTP, OP_READ, 0, 0, L, 0, 0, 1);
        `CHK("roWd0", 32'h1234_5678, p.rD)
        t("roWr", ZONE_OTP, OP_WRITE, 0, 0, 0, 0, 32'h0000_0000, 0);
        t("roRd0", ZONE_OTP, OP_READ, 0, 0, 0, 0, 0, 1);
        `CHK("roKept", 32'h1234_5678, p.rD)
        t("roRd15", ZONE_OTP, OP_READ, 5'h0F, 0, 0, 0, 0, 1);
        `CHK("roWd15", 32'hFFFF_FFFF, p.rD)
    endtask

    task slots;
        t("alwWr", ZONE_DATA, OP_WRITE, 0, 0, 0, 0, 0, 1);
        t("alwWrL", ZONE_DATA, OP_WRITE, 0, 0, L, 0, 0, 1);
        t("secRd", ZONE_DATA, OP_READ, 0, 5, 0, 0, 0, 0);
        t("secWr", ZONE_DATA, OP_WRITE, 0, 5, 0, 0, 0, 0);
        t("encRd", ZONE_DATA, OP_READ, 0, 6, L | E, 0, 0, 1);
        t("clrRd", ZONE_DATA, OP_READ, 0, 6, L, 0, 0, 0);
        t("nevWr", ZONE_DATA, OP_WRITE, 0, 1, L | M | E, 1, 0, 0);
        t("encWr", ZONE_DATA, OP_WRITE, 0, 2, L | M | E, 3, 0, 1);
        `CHK("encMac", 1'b1, p.rM)
        t("encSh", ZONE_DATA, OP_WRITE, 0, 2, M | E, 3, 0, 0);
        t("encPl", ZONE_DATA, OP_WRITE, 0, 2, L | M, 3, 0, 0);
        t("selfK", ZONE_DATA, OP_WRITE, 0, 4, L | M | E, 4, 0, 1);
        t("otherK", ZONE_DATA, OP_WRITE, 0, 4, L | M | E, 3, 0, 0);
        t("noDrv", ZONE_DATA, OP_DERIVE, 0, 0, M, 0, 0, 0);
        t("roll", ZONE_DATA, OP_DERIVE, 0, 1, 0, 0, 0, 1);
        `CHK("rollSrc", 4'h1, p.rS)
        `CHK("rollMac", 1'b0, p.rM)
        t("crNoMac", ZONE_DATA, OP_DERIVE, 0, 3, 0, 0, 0, 0);
        t("create", ZONE_DATA, OP_DERIVE, 0, 3, M, 0, 0, 1);
        `CHK("crSrc", 4'h5, p.rS)
    endtask

    task legacy;
        t("lgRd0", ZONE_OTP, OP_READ, 0, 0, 0, 0, 0, 0);
        t("lgRd1", ZONE_OTP, OP_READ, 1, 0, 0, 0, 0, 0);
        t("lgRd2", ZONE_OTP, OP_READ, 2, 0, 0, 0, 0, 1);
        `CHK("lgWd2", 32'hFFFF_FFFF, p.rD)
        t("lgRd2L", ZONE_OTP, OP_READ, 2, 0, L, 0, 0, 0);
        t("lgWr", ZONE_OTP, OP_WRITE, 3, 0, 0, 0, 0, 0);
    endtask

    // Second pass after a mid-run reset covers the other OTP policy
    initial begin
        doReset;
        cfgPhase(8'hAA);
        perso;
        lockedRo;
        slots;
        doReset;
        cfgPhase(8'h00);
        perso;
        legacy;
        finish_test;
    end
endmodule
`default_nettype wire
